// *** verilog/phase_meter_pkg.sv ***
// Purpose: constants and types for the phase meter divider and output block
// Assumes: 100 MHz core clock, synchronous inputs, APB register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package phase_meter_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_FS = 10000000;
    localparam int PHASE_STEP_FS = 12500;
    localparam int STEPS_PER_CYC = CLK_PERIOD_FS / PHASE_STEP_FS;
    localparam int SHOT_NS = 10000;
    localparam int SHOT_CYC = (SHOT_NS * CLK_MHZ + 999) / 1000;
    localparam int SAMPLE_MIN_US = 1000;
    localparam int TICK_CYC = SAMPLE_MIN_US * CLK_MHZ;
    localparam int METER_DIV_HALF = 100;
    localparam int LOOP_DIV = 9999;
    localparam int LOOP1_DIV_HI = 10;
    localparam int LOOP1_DIV_LO = 20;
    localparam int DET_WIN_CYC = 100;
    localparam int DET_THRESH = 7;
    localparam int DEC_BASE = 100;
    localparam int DEC_MAX = 6;
    localparam int TAU_MAX_IDX = 19;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TAU_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] PHASE_OFS = 8'h0c;
    localparam logic [7:0] FREQ_OFS = 8'h10;
    localparam logic [7:0] METER_OFS = 8'h14;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_DEC_LSB = 1;
    localparam int CTRL_AVG_BIT = 4;
    localparam int CTRL_RANGE_LSB = 5;
    localparam int CTRL_FACTOR_BIT = 7;
    localparam int CTRL_TCM_LSB = 8;
    localparam int CTRL_RUN_BIT = 10;
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [4:0] TAU_RST = 5'h00;
    typedef enum logic [1:0] {M_IDLE = 2'b01, M_RUN = 2'b10} meter_state_e;
endpackage

// *** verilog/phase_meter_divider_outputs.sv ***
// Purpose: divider chains, one-shots, counter routing, phase meter, meter control
// Assumes: all pin inputs synchronous to CORE_CLK, which is the 100 MHz oscillator
// Notes: APB answers with PREADY one cycle after setup, no wait states
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module phase_meter_divider_outputs #(
    parameter int TICK = phase_meter_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // signal inputs
    input wire logic IF_SQUARE,
    input wire logic REF_100K,
    input wire logic METER_IF_500,
    input wire logic REF_INPUT,
    input wire logic LO_DIV_IN,
    // counter outputs
    output logic COUNTER_A,
    output logic COUNTER_B,
    // meter circuit
    output logic METER_REF_500,
    output logic METER_POS_PULSE,
    output logic METER_NEG_PULSE,
    output logic [13:0] LOOP_DIV_RATIO,
    output logic [3:0] FULL_SCALE_SETTING,
    output logic [16:0] METER_TC_MS,
    // multiplier control
    output logic LO_DIV_RETIMED,
    output logic [4:0] LOOP1_DIV_RATIO,
    output logic INPUT_10M
);
    import phase_meter_pkg::*;
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [10:0] ctrl;
        logic [4:0] tau;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0][26:0] div_cnt;
        logic [3:0][9:0] shot_cnt;
        logic cnt_a;
        logic cnt_b;
        logic [6:0] mdiv_cnt;
        logic mref;
        logic mpos;
        logic mneg;
        logic [6:0] det_win;
        logic [4:0] det_edges;
        logic hi;
        logic [4:0] loop1;
        logic lo_rt;
        meter_state_e pstate;
        logic [9:0] pcnt;
        logic [19:0] phase_latest;
        logic [16:0] tick_cnt;
        logic [20:0] ms_cnt;
        logic [40:0] acc;
        logic [31:0] phase_res;
        logic [31:0] freq_res;
        logic have_prev;
        logic new_flag;
        logic [15:0] nsamp;
        logic [3:0] full_scale_setting;
        logic [16:0] tc;
    } state_s;
    state_s r_reg;
    state_s r_next;
    logic [3:0] edges;
    // decade ratio: 100 gives 1kHz, each step up to setting 6 a further ten
    function automatic logic [26:0] dec_ratio(input logic [2:0] d);
        logic [26:0] v;
        v = 27'(DEC_BASE);
        for (int k = 0; k < DEC_MAX; k++) begin
            if (k < int'(d)) begin
                v = 27'(v * 27'd10);
            end
        end
        return v;
    endfunction
    // interval in ms, 1-2-5 per decade from 1ms upward
    function automatic logic [20:0] tau_ms(input logic [4:0] idx);
        logic [20:0] v;
        logic [4:0] dec;
        dec = 5'(idx / 5'd3);
        v = (idx % 5'd3 == 5'd0) ? 21'd1 : (idx % 5'd3 == 5'd1) ? 21'd2 : 21'd5;
        for (int k = 0; k < 7; k++) begin
            if (k < int'(dec)) begin
                v = 21'(v * 21'd10);
            end
        end
        return v;
    endfunction
    function automatic logic [16:0] tc_calc(input logic [1:0] rng, input logic [1:0] m);
        logic [16:0] b;
        unique case (rng)
            2'h0: b = 17'd20;
            2'h1: b = 17'd100;
            2'h2: b = 17'd1000;
            default: b = 17'd10000;
        endcase
        return (m == 2'h1) ? 17'(b * 17'd3) : (m == 2'h2) ? 17'(b * 17'd10) : b;
    endfunction
    assign edges = r_reg.sync2 & ~r_reg.prev;
    always_comb begin
        logic [3:0] trig;
        logic tick;
        logic [20:0] tmsv;
        logic [40:0] avg41;
        logic [31:0] smp;
        trig = 4'h0;
        tick = 1'b0;
        tmsv = tau_ms(r_reg.tau);
        avg41 = 41'h0;
        smp = 32'h0;
        r_next = r_reg;
        // first stage feeds only the second; edges look at stage two
        r_next.sync1 = {REF_INPUT, METER_IF_500, REF_100K, IF_SQUARE};
        r_next.sync2 = r_reg.sync1;
        r_next.prev = r_reg.sync2;
        // apb: setup cycle prepares the answer, access cycle completes
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        if (PSEL && !PENABLE) begin
            r_next.pready = 1'b1;
            r_next.prdata = 32'h0;
            unique case (PADDR)
                CTRL_OFS: r_next.prdata = {21'h0, r_reg.ctrl};
                TAU_OFS: r_next.prdata = {27'h0, r_reg.tau};
                STATUS_OFS: r_next.prdata = {r_reg.new_flag, r_reg.hi,
                    r_reg.pstate == M_RUN, 13'h0, r_reg.nsamp};
                PHASE_OFS: r_next.prdata = r_reg.phase_res;
                FREQ_OFS: r_next.prdata = r_reg.freq_res;
                METER_OFS: r_next.prdata = {11'h0, r_reg.full_scale_setting, r_reg.tc};
                default: r_next.pslverr = 1'b1;
            endcase
        end
        if (PSEL && PENABLE && r_reg.pready) begin
            if (PWRITE && PADDR == CTRL_OFS) begin
                r_next.ctrl = PWDATA[10:0];
            end
            // sampling interval comes from here and nowhere else
            if (PWRITE && PADDR == TAU_OFS) begin
                r_next.tau = (PWDATA[4:0] > 5'(TAU_MAX_IDX)) ? 5'(TAU_MAX_IDX) : PWDATA[4:0];
            end
            if (!PWRITE && PADDR == PHASE_OFS) begin
                r_next.new_flag = 1'b0;
            end
        end
        // identical chains, one shared decade setting
        for (int ch = 0; ch < 2; ch++) begin
            if (edges[ch]) begin
                if (r_reg.div_cnt[ch] >= dec_ratio(r_reg.ctrl[CTRL_DEC_LSB +: 3]) - 27'd1) begin
                    r_next.div_cnt[ch] = 27'h0;
                    trig[ch] = 1'b1;
                end else begin
                    r_next.div_cnt[ch] = r_reg.div_cnt[ch] + 27'd1;
                end
            end
        end
        // reference down to 500Hz for the meter loop
        if (edges[1]) begin
            if (r_reg.mdiv_cnt == 7'(METER_DIV_HALF - 1)) begin
                r_next.mdiv_cnt = 7'h0;
                r_next.mref = !r_reg.mref;
                trig[3] = !r_reg.mref;
            end else begin
                r_next.mdiv_cnt = r_reg.mdiv_cnt + 7'd1;
            end
        end
        trig[2] = edges[2];
        // counted one-shots; a trigger while busy is dropped
        for (int k = 0; k < 4; k++) begin
            if (r_reg.shot_cnt[k] != 10'h0) begin
                r_next.shot_cnt[k] = r_reg.shot_cnt[k] - 10'd1;
            end else if (trig[k]) begin
                r_next.shot_cnt[k] = 10'(SHOT_CYC);
            end
        end
        r_next.mpos = r_next.shot_cnt[2] != 10'h0;
        r_next.mneg = r_next.shot_cnt[3] != 10'h0;
        // mode picks the counter routing
        if (r_reg.ctrl[CTRL_MODE_BIT]) begin
            r_next.cnt_a = r_next.shot_cnt[0] != 10'h0;
            r_next.cnt_b = r_next.shot_cnt[1] != 10'h0;
        end else begin
            r_next.cnt_a = r_reg.sync2[0];
            r_next.cnt_b = 1'b0;
        end
        // count input edges in a short window to tell 10MHz from 5MHz
        if (r_reg.det_win == 7'(DET_WIN_CYC - 1)) begin
            r_next.det_win = 7'h0;
            r_next.det_edges = 5'h0;
            r_next.hi = (r_reg.det_edges + 5'(edges[3])) >= 5'(DET_THRESH);
        end else begin
            r_next.det_win = r_reg.det_win + 7'd1;
            r_next.det_edges = r_reg.det_edges + 5'(edges[3]);
        end
        r_next.loop1 = r_next.hi ? 5'(LOOP1_DIV_HI) : 5'(LOOP1_DIV_LO);
        r_next.lo_rt = LO_DIV_IN;
        // full scale and time constant from range, factor, rear switch
        r_next.full_scale_setting = (r_reg.ctrl[CTRL_FACTOR_BIT] ? 4'd9 : 4'd7)
            + {2'b00, r_reg.ctrl[CTRL_RANGE_LSB +: 2]};
        r_next.tc = tc_calc(r_reg.ctrl[CTRL_RANGE_LSB +: 2],
            r_reg.ctrl[CTRL_TCM_LSB +: 2]);
        // time from reference edge to IF edge, one clock is 800 steps
        // restart at one so the clock of the reference edge itself is counted
        if (edges[1]) begin
            r_next.pcnt = 10'h1;
        end else if (r_reg.pcnt != 10'h3ff) begin
            r_next.pcnt = r_reg.pcnt + 10'd1;
        end
        if (edges[0]) begin
            r_next.phase_latest = edges[1] ? 20'h0 : 20'(r_reg.pcnt * 20'(STEPS_PER_CYC));
        end
        unique case (r_reg.pstate)
            M_IDLE: begin
                r_next.tick_cnt = 17'h0;
                r_next.ms_cnt = 21'h0;
                r_next.acc = 41'h0;
                if (r_reg.ctrl[CTRL_RUN_BIT]) begin
                    r_next.pstate = M_RUN;
                    r_next.have_prev = 1'b0;
                end
            end
            M_RUN: begin
                // one sample opportunity per millisecond at most
                if (r_reg.tick_cnt == 17'(TICK - 1)) begin
                    r_next.tick_cnt = 17'h0;
                    tick = 1'b1;
                end else begin
                    r_next.tick_cnt = r_reg.tick_cnt + 17'd1;
                end
                if (tick) begin
                    if (r_reg.ms_cnt >= tmsv - 21'd1) begin
                        // block mean over the interval, or the single last sample
                        avg41 = (r_reg.acc + 41'(r_reg.phase_latest)) / 41'(tmsv);
                        smp = r_reg.ctrl[CTRL_AVG_BIT] ? avg41[31:0]
                            : 32'(r_reg.phase_latest);
                        r_next.phase_res = smp;
                        r_next.freq_res = r_reg.have_prev ? smp - r_reg.phase_res : 32'h0;
                        r_next.have_prev = 1'b1;
                        r_next.new_flag = 1'b1;
                        r_next.nsamp = r_reg.nsamp + 16'd1;
                        r_next.ms_cnt = 21'h0;
                        r_next.acc = 41'h0;
                    end else begin
                        r_next.ms_cnt = r_reg.ms_cnt + 21'd1;
                        if (r_reg.ctrl[CTRL_AVG_BIT]) begin
                            r_next.acc = r_reg.acc + 41'(r_reg.phase_latest);
                        end
                    end
                end
                if (!r_reg.ctrl[CTRL_RUN_BIT]) begin
                    r_next.pstate = M_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            r_reg <= '0;
            r_reg.ctrl <= CTRL_RST;
            r_reg.tau <= TAU_RST;
            r_reg.pstate <= M_IDLE;
            r_reg.loop1 <= 5'(LOOP1_DIV_LO);
            r_reg.full_scale_setting <= 4'd7;
            r_reg.tc <= 17'd20;
        end else begin
            r_reg <= r_next;
        end
    end
    assign PRDATA = r_reg.prdata;
    assign PREADY = r_reg.pready;
    assign PSLVERR = r_reg.pslverr;
    assign COUNTER_A = r_reg.cnt_a;
    assign COUNTER_B = r_reg.cnt_b;
    assign METER_REF_500 = r_reg.mref;
    assign METER_POS_PULSE = r_reg.mpos;
    assign METER_NEG_PULSE = r_reg.mneg;
    assign LOOP_DIV_RATIO = 14'(LOOP_DIV);
    assign FULL_SCALE_SETTING = r_reg.full_scale_setting;
    assign METER_TC_MS = r_reg.tc;
    assign LO_DIV_RETIMED = r_reg.lo_rt;
    assign LOOP1_DIV_RATIO = r_reg.loop1;
    assign INPUT_10M = r_reg.hi;
    // helper: length of the meter positive pulse
    logic [10:0] pos_len;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pos_len <= 11'h0;
        end else begin
            pos_len <= METER_POS_PULSE ? pos_len + 11'd1 : 11'h0;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    freq_route_a: assert property (!r_reg.ctrl[CTRL_MODE_BIT] && $stable(r_reg.ctrl)
        |=> COUNTER_A == $past(r_reg.sync2[0]) && !COUNTER_B) else $error("freq route");
    phase_route_a: assert property (r_reg.ctrl[CTRL_MODE_BIT] && $stable(r_reg.ctrl)
        && edges[1] && r_reg.shot_cnt[1] == 10'h0 && r_reg.div_cnt[1] >=
        dec_ratio(r_reg.ctrl[CTRL_DEC_LSB +: 3]) - 27'd1 |=> COUNTER_B) else $error("phase route");
    shot_width_a: assert property ($fell(METER_POS_PULSE)
        |-> pos_len == 11'(SHOT_CYC)) else $error("one-shot width");
    shot_hold_a: assert property ($rose(METER_NEG_PULSE)
        |-> METER_NEG_PULSE [*8]) else $error("one-shot too short");
    sample_tick_a: assert property (r_reg.nsamp != $past(r_reg.nsamp)
        |-> $past(r_reg.tick_cnt) == 17'(TICK - 1)) else $error("sample off tick");
    flag_set_a: assert property (r_next.nsamp != r_reg.nsamp
        |=> r_reg.new_flag) else $error("sample flag lost");
    detect_hi_a: assert property (r_reg.det_win == 7'(DET_WIN_CYC - 1)
        && r_reg.det_edges >= 5'(DET_THRESH) |=> ##1 LOOP1_DIV_RATIO == 5'(LOOP1_DIV_HI))
        else $error("divide ratio not ten");
    fsd_map_a: assert property ($stable(r_reg.ctrl) [*2] |-> FULL_SCALE_SETTING ==
        (r_reg.ctrl[CTRL_FACTOR_BIT] ? 4'd9 : 4'd7) + {2'b00, r_reg.ctrl[CTRL_RANGE_LSB +: 2]})
        else $error("full scale wrong");
    tc_map_a: assert property ($stable(r_reg.ctrl) [*2] |-> METER_TC_MS >= 17'd20
        && METER_TC_MS <= 17'd100000) else $error("time constant range");
    retime_a: assert property (LO_DIV_RETIMED == $past(LO_DIV_IN))
        else $error("retime missing");
    apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("apb ready timing");
    phase_mode_c: cover property (r_reg.ctrl[CTRL_MODE_BIT] && $rose(COUNTER_B));
    avg_sample_c: cover property (r_reg.ctrl[CTRL_AVG_BIT] && r_reg.new_flag);
    detect_10m_c: cover property ($rose(INPUT_10M));
    meter_pulse_c: cover property ($rose(METER_POS_PULSE));
endmodule

// *** dv/pulse_tally.sv ***
// Purpose: far-side counter model that tallies pulses on one counter channel
// Assumes: channel is sampled on the core clock, like a gated counter input
// Notes: reports pulse count, last high width and last rise-to-rise period
`timescale 1ns/1ps
module pulse_tally (
    // clock and clear
    input wire logic clk,
    input wire logic rst,
    // observed channel
    input wire logic pin,
    // results
    output logic [15:0] pulses,
    output logic [15:0] width,
    output logic [15:0] period
);
    logic last = 1'b0;
    logic [15:0] hi_cnt = 16'h0000;
    logic [15:0] per_cnt = 16'h0000;
    // widths are whole clocks, so a one-shot that is one clock short shows as a wrong width
    always_ff @(posedge clk) begin
        last <= pin;
        hi_cnt <= pin ? hi_cnt + 16'h0001 : 16'h0000;
        per_cnt <= (pin && !last) ? 16'h0001 : per_cnt + 16'h0001;
        if (rst) begin
            pulses <= 16'h0000;
            width <= 16'h0000;
            period <= 16'h0000;
        end else begin
            if (pin && !last) begin
                pulses <= pulses + 16'h0001;
                period <= per_cnt;
            end
            if (!pin && last) begin
                width <= hi_cnt;
            end
        end
    end
endmodule

// *** dv/phase_meter_divider_outputs_tb_top.sv ***
// Purpose: self-checking bench for the divider, one-shot and phase meter block
// Assumes: TICK shortened to 50 clocks, so one tau millisecond is 50 clocks
// Notes: apb reads queue their expected word; a monitor pops it at pready
`timescale 1ns/1ps
module phase_meter_divider_outputs_tb_top;
    import phase_meter_pkg::*;
    localparam int TICK_SIM = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    logic if_sq = 1'b0, ref_100k = 1'b0, meter_if = 1'b0, ref_in = 1'b0, lo_in = 1'b0;
    logic cnt_a, cnt_b, m_ref, m_pos, m_neg, lo_rt, in10m;
    logic [13:0] loop_div;
    logic [3:0] fss;
    logic [16:0] tc_ms;
    logic [4:0] loop1;
    logic gen_on = 1'b0, rnd_on = 1'b0, tclr = 1'b0, lo_h = 1'b0;
    logic [2:0] hist = 3'h0;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    logic [15:0] pa, wa, pb, wb, wp, wn, wr_w, rp;
    integer seed = 32'hdce9;
    int fails = 0, check_count = 0, ph = 0, rc = 0, rcnt = 0, mcnt = 0, ref_half = 0;
    int fs_e, tc_e;
    int base[4] = '{20, 100, 1000, 10000};
    int mul[4] = '{1, 3, 10, 1};

    initial begin
        forever #5 clk = ~clk;
    end

    phase_meter_divider_outputs #(.TICK(TICK_SIM)) u_dut (
        .CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IF_SQUARE(if_sq), .REF_100K(ref_100k), .METER_IF_500(meter_if), .REF_INPUT(ref_in),
        .LO_DIV_IN(lo_in), .COUNTER_A(cnt_a), .COUNTER_B(cnt_b), .METER_REF_500(m_ref),
        .METER_POS_PULSE(m_pos), .METER_NEG_PULSE(m_neg), .LOOP_DIV_RATIO(loop_div),
        .FULL_SCALE_SETTING(fss), .METER_TC_MS(tc_ms), .LO_DIV_RETIMED(lo_rt),
        .LOOP1_DIV_RATIO(loop1), .INPUT_10M(in10m));

    pulse_tally u_ta (.clk(clk), .rst(rst | tclr), .pin(cnt_a), .pulses(pa), .width(wa), .period());
    pulse_tally u_tb (.clk(clk), .rst(rst | tclr), .pin(cnt_b), .pulses(pb), .width(wb), .period());
    pulse_tally u_tp (.clk(clk), .rst(rst), .pin(m_pos), .pulses(), .width(wp), .period());
    pulse_tally u_tn (.clk(clk), .rst(rst), .pin(m_neg), .pulses(), .width(wn), .period());
    pulse_tally u_tr (.clk(clk), .rst(rst), .pin(m_ref), .pulses(), .width(wr_w), .period(rp));

    // stimulus: 20-clock IF and reference squares, IF lagging by 3 clocks
    always @(posedge clk) begin
        if (gen_on) begin
            ph <= (ph + 1) % 20;
            ref_100k <= (ph < 10);
            if_sq <= (((ph + 17) % 20) < 10);
            mcnt <= (mcnt + 1) % 1500;
            if (mcnt == 0) begin
                meter_if <= ~meter_if;
            end
        end else if (rnd_on) begin
            if_sq <= 1'($random(seed));
            lo_in <= 1'($random(seed));
        end
        rcnt <= (ref_half == 0) ? 0 : (rcnt + 1) % ref_half;
        if (ref_half != 0 && rcnt == 0) begin
            ref_in <= ~ref_in;
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, x, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // monitor: oldest read note against the access phase, stream checks in freq mode
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            chk("prdata", prdata & e[63:32], e[31:0]);
            chk("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
        end
        hist <= {hist[1:0], if_sq};
        lo_h <= lo_in;
        rc <= rnd_on ? rc + 1 : 0;
        if (rc > 4) begin
            chk("counter_a", {31'h0, cnt_a}, {31'h0, hist[2]});
            chk("counter_b", {31'h0, cnt_b}, 32'h0);
            chk("lo_retimed", {31'h0, lo_rt}, {31'h0, lo_h});
        end
    end

    // one transfer; waits on pready with a bound, never on a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic er);
        int n;
        n = 0;
        if (!w) begin
            exp_q.push_back({er, m, d});
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
        apb(1'b0, a, x, m, 1'b0);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL_OFS, 32'h0);
        rd(TAU_OFS, 32'h0);
        rd(METER_OFS, 32'h000e0014);
        chk("loop_div", {18'h0, loop_div}, 32'd9999);
        chk("loop1", {27'h0, loop1}, 32'd20);
        apb(1'b0, 8'h18, 32'h0, '1, 1'b1);
        wr(TAU_OFS, 32'h1f);
        rd(TAU_OFS, 32'd19);
        for (int f = 0; f < 2; f++) begin
            for (int r = 0; r < 4; r++) begin
                for (int t = 0; t < 4; t++) begin
                    fs_e = (f == 1 ? 9 : 7) + r;
                    tc_e = base[r] * mul[t];
                    wr(CTRL_OFS, 32'((f << 7) | (r << 5) | (t << 8)));
                    repeat (2) @(posedge clk);
                    chk("full_scale", {28'h0, fss}, 32'(fs_e));
                    chk("meter_tc", {15'h0, tc_ms}, 32'(tc_e));
                    rd(METER_OFS, 32'((fs_e << 17) | tc_e));
                end
            end
        end
        wr(CTRL_OFS, 32'h0);
        rnd_on <= 1'b1;
        repeat (60) @(posedge clk);
        rnd_on <= 1'b0;
        ref_half <= 5;
        repeat (400) @(posedge clk);
        chk("input_10m", {31'h0, in10m}, 32'h1);
        chk("loop1", {27'h0, loop1}, 32'd10);
        rd(STATUS_OFS, 32'h40000000, 32'h40000000);
        ref_half <= 10;
        repeat (400) @(posedge clk);
        chk("input_10m", {31'h0, in10m}, 32'h0);
        chk("loop1", {27'h0, loop1}, 32'd20);
        // counters cleared so that random freq-mode edges do not pollute the tally
        tclr <= 1'b1;
        wr(CTRL_OFS, 32'h1);
        tclr <= 1'b0;
        gen_on <= 1'b1;
        repeat (8000) @(posedge clk);
        chk("pulses_ab", {16'h0, pa}, {16'h0, pb});
        chk("pulses_seen", {31'h0, pa >= 16'd3}, 32'h1);
        chk("width_a", {16'h0, wa}, 32'(SHOT_CYC));
        chk("width_b", {16'h0, wb}, 32'(SHOT_CYC));
        chk("width_pos", {16'h0, wp}, 32'(SHOT_CYC));
        chk("width_neg", {16'h0, wn}, 32'(SHOT_CYC));
        chk("ref500_high", {16'h0, wr_w}, 32'd2000);
        chk("ref500_period", {16'h0, rp}, 32'd4000);
        wr(TAU_OFS, 32'h2);
        wr(CTRL_OFS, 32'h401);
        repeat (1010) @(posedge clk);
        rd(STATUS_OFS, 32'h20000004, 32'h2000ffff);
        rd(PHASE_OFS, 32'(3 * STEPS_PER_CYC));
        rd(FREQ_OFS, 32'h0);
        wr(CTRL_OFS, 32'h411);
        repeat (600) @(posedge clk);
        rd(PHASE_OFS, 32'(3 * STEPS_PER_CYC));
        conclude();
    end
endmodule
